// >>> rtl/gpc_pkg.sv
// constants for the grayscale palette command decoder
package gpc_pkg;

  localparam int unsigned BYTE_W = 8;
  localparam int unsigned NIB_W  = 4;
  localparam int unsigned NUM_SLOTS = 8;

  // first byte: upper five bits fixed, low three pick level and frame pair
  localparam logic [4:0] PAL_PREFIX = 5'h11;
  localparam int unsigned PREFIX_LSB = 3;
  localparam int unsigned SLOT_MSB   = 2;

  // slot indices: level*2 + pair
  localparam logic [2:0] SLOT_WHITE_12 = 3'h0;
  localparam logic [2:0] SLOT_WHITE_34 = 3'h1;
  localparam logic [2:0] SLOT_LIGHT_12 = 3'h2;
  localparam logic [2:0] SLOT_LIGHT_34 = 3'h3;
  localparam logic [2:0] SLOT_DARK_12  = 3'h4;
  localparam logic [2:0] SLOT_DARK_34  = 3'h5;
  localparam logic [2:0] SLOT_BLACK_12 = 3'h6;
  localparam logic [2:0] SLOT_BLACK_34 = 3'h7;

  localparam logic [7:0] WIDTH_RESET = 8'h00;

  typedef enum logic [0:0] {
    GPC_IDLE     = 1'b0,
    GPC_WAIT_ARG = 1'b1
  } gpc_state_type;

  function automatic logic is_palette_cmd(input logic [7:0] b);
    return b[7:PREFIX_LSB] == PAL_PREFIX;
  endfunction : is_palette_cmd

endpackage : gpc_pkg

// >>> rtl/gpc_sync.sv
// two-flop synchroniser for pin-side levels
module gpc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule : gpc_sync

// >>> rtl/gpc_decode.sv
// grayscale palette command decoder with palette width storage
// Operation
// [RQ1] white command: selector byte then two widths
// [RQ2] light gray command: selector then two widths
// [RQ3] dark gray command: selector then two widths
// [RQ4] black command: selector then two widths
// [RQ5] low nibble earlier frame; command mode only
module gpc_decode
  import gpc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        soft_reset,
  input  wire logic        register_select,
  input  wire logic        write_strobe,
  input  wire logic [7:0]  data_in,
  output logic      [3:0]  white_width_frame1,
  output logic      [3:0]  white_width_frame2,
  output logic      [3:0]  white_width_frame3,
  output logic      [3:0]  white_width_frame4,
  output logic      [3:0]  light_width_frame1,
  output logic      [3:0]  light_width_frame2,
  output logic      [3:0]  light_width_frame3,
  output logic      [3:0]  light_width_frame4,
  output logic      [3:0]  dark_width_frame1,
  output logic      [3:0]  dark_width_frame2,
  output logic      [3:0]  dark_width_frame3,
  output logic      [3:0]  dark_width_frame4,
  output logic      [3:0]  black_width_frame1,
  output logic      [3:0]  black_width_frame2,
  output logic      [3:0]  black_width_frame3,
  output logic      [3:0]  black_width_frame4,
  output logic             arg_pending
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation; data is held stable around the strobe by the host
  logic [9:0] pins_sync;
  logic       rs_s;
  logic       wr_s;
  logic [7:0] data_s;

  gpc_sync #(.W(10)) u_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in ({register_select, write_strobe, data_in}),
    .sync_out (pins_sync)
  );

  assign rs_s   = pins_sync[9];
  assign wr_s   = pins_sync[8];
  assign data_s = pins_sync[7:0];

  // rising edge of the synchronised strobe marks one byte
  logic wr_prev_q;
  logic wr_prev_d;
  logic byte_take;

  always_comb begin
    wr_prev_d = wr_s;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_prev_q <= 1'b0;
    end else begin
      wr_prev_q <= wr_prev_d;
    end
  end

  // data bytes (select high) never touch the palette
  assign byte_take = wr_s && !wr_prev_q && !rs_s; // RQ5

  ////////////////////////////////////////////////////////////////////////////
  // byte capture: one stage between edge detect and decode keeps the
  // selector compare off the synchroniser output; costs one cycle
  logic       take_q;
  logic       take_d;
  logic [7:0] byte_q;
  logic [7:0] byte_d;

  always_comb begin
    // a byte caught with soft reset is dropped along with the rest
    take_d = byte_take && !soft_reset;
    byte_d = byte_q;
    if (byte_take) begin
      byte_d = data_s;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      take_q <= 1'b0;
      byte_q <= '0;
    end else begin
      take_q <= take_d;
      byte_q <= byte_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-byte sequencer
  gpc_state_type state_q;
  gpc_state_type state_d;
  logic [2:0]    slot_q;
  logic [2:0]    slot_d;
  logic          store_en;

  always_comb begin
    state_d  = state_q;
    slot_d   = slot_q;
    store_en = 1'b0;
    if (soft_reset) begin
      state_d = GPC_IDLE;
      slot_d  = 3'h0;
    end else if (take_q) begin
      case (state_q)
        GPC_IDLE: begin
          // other commands pass by untouched
          if (is_palette_cmd(byte_q)) begin // RQ1 RQ2 RQ3 RQ4
            slot_d  = byte_q[SLOT_MSB:0];
            state_d = GPC_WAIT_ARG;
          end
        end
        GPC_WAIT_ARG: begin
          // any byte completes the command, even one looking like a selector
          store_en = 1'b1;
          state_d  = GPC_IDLE;
        end
        default: begin
          state_d = GPC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= GPC_IDLE;
      slot_q  <= 3'h0;
    end else begin
      state_q <= state_d;
      slot_q  <= slot_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // width storage; soft reset wins over a store in the same cycle
  logic [7:0] width_q [NUM_SLOTS];
  logic [7:0] width_d [NUM_SLOTS];

  always_comb begin
    width_d = width_q;
    if (soft_reset) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        width_d[i] = WIDTH_RESET;
      end
    end else if (store_en) begin
      width_d[slot_q] = byte_q; // RQ1 RQ2 RQ3 RQ4
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        width_q[i] <= WIDTH_RESET;
      end
    end else begin
      width_q <= width_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // nibble split: low nibble is the earlier frame
  assign white_width_frame1 = width_q[SLOT_WHITE_12][3:0]; // RQ5
  assign white_width_frame2 = width_q[SLOT_WHITE_12][7:4]; // RQ5
  assign white_width_frame3 = width_q[SLOT_WHITE_34][3:0];
  assign white_width_frame4 = width_q[SLOT_WHITE_34][7:4];
  assign light_width_frame1 = width_q[SLOT_LIGHT_12][3:0];
  assign light_width_frame2 = width_q[SLOT_LIGHT_12][7:4];
  assign light_width_frame3 = width_q[SLOT_LIGHT_34][3:0];
  assign light_width_frame4 = width_q[SLOT_LIGHT_34][7:4];
  assign dark_width_frame1  = width_q[SLOT_DARK_12][3:0];
  assign dark_width_frame2  = width_q[SLOT_DARK_12][7:4];
  assign dark_width_frame3  = width_q[SLOT_DARK_34][3:0];
  assign dark_width_frame4  = width_q[SLOT_DARK_34][7:4];
  assign black_width_frame1 = width_q[SLOT_BLACK_12][3:0];
  assign black_width_frame2 = width_q[SLOT_BLACK_12][7:4];
  assign black_width_frame3 = width_q[SLOT_BLACK_34][3:0];
  assign black_width_frame4 = width_q[SLOT_BLACK_34][7:4];
  assign arg_pending        = (state_q == GPC_WAIT_ARG);

endmodule : gpc_decode

// >>> tb/gpc_host.sv
// host model writing command bytes on the parallel pins
module gpc_host (
  input  wire logic       mclk,
  output logic            register_select,
  output logic            write_strobe,
  output logic      [7:0] data_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    register_select = 1'b1;
    write_strobe = 1'b0;
    data_in = 8'hFF;
  end
  // four edges high and low, three above the one-edge minimum
  task automatic send(input logic rs, input logic [7:0] b);
    @(posedge mclk) #5;
    register_select = rs;
    data_in = b;
    // data settles a cycle ahead so it never races the strobe
    @(posedge mclk) #5;
    write_strobe = 1'b1;
    repeat (4) @(posedge mclk) #5;
    write_strobe = 1'b0;
    repeat (4) @(posedge mclk) #5;
    data_in = ~b;
  endtask : send
endmodule : gpc_host

// >>> tb/gpc_assertions.sv
// port checks for the palette decoder
module gpc_checker (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       soft_reset,
  input wire logic       register_select,
  input wire logic       arg_pending,
  input wire logic [3:0] white_width_frame1,
  input wire logic [3:0] black_width_frame4
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_arg;
    $rose(arg_pending) ##1 !soft_reset[*3];
  endsequence
  white_src_a: assert property (!$stable(white_width_frame1) && !$past(soft_reset)
    |-> $past(arg_pending)) else $error("white width moved without argument");
  black_src_a: assert property (!$stable(black_width_frame4) && !$past(soft_reset)
    |-> $past(arg_pending)) else $error("black width moved without argument");
  pend_hold_a: assert property (s_arg |-> arg_pending)
    else $error("pending dropped early");
  soft_clear_a: assert property (soft_reset |=> !arg_pending && white_width_frame1 == 4'h0
    && black_width_frame4 == 4'h0) else $error("soft reset left state");
  data_mode_a: assert property (register_select[*6] ##0 !$past(soft_reset)
    |-> $stable(arg_pending)) else $error("data byte moved sequencer");
endmodule : gpc_checker
bind gpc_decode gpc_checker i_chk (.mclk(mclk), .rst_n(rst_n), .soft_reset(soft_reset),
  .register_select(register_select), .arg_pending(arg_pending),
  .white_width_frame1(white_width_frame1), .black_width_frame4(black_width_frame4));

// >>> tb/gray_palette_command_decode_tb.sv
// self-checking bench for the palette command decoder
module gray_palette_command_decode_tb;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
  logic mclk = 1'b0, rst_n = 1'b0, soft_reset = 1'b0, register_select, write_strobe;
  logic [7:0] data_in;
  logic [3:0] white_width_frame1, white_width_frame2, white_width_frame3, white_width_frame4;
  logic [3:0] light_width_frame1, light_width_frame2, light_width_frame3, light_width_frame4;
  logic [3:0] dark_width_frame1, dark_width_frame2, dark_width_frame3, dark_width_frame4;
  logic [3:0] black_width_frame1, black_width_frame2, black_width_frame3, black_width_frame4;
  logic       arg_pending;
  logic [7:0] got [8];
  int         err_count = 0;
  int         num_checks = 0;
  // argument per slot; stored width pair must equal it
  logic [7:0] rows [8] = '{8'h21, 8'h43, 8'h65, 8'h87, 8'hA9, 8'hCB, 8'hED, 8'h0F};
  always #25 mclk = ~mclk;
  gpc_decode i_dut (.*);
  gpc_host i_host (.mclk(mclk), .register_select(register_select),
    .write_strobe(write_strobe), .data_in(data_in));
  assign got = '{{white_width_frame2, white_width_frame1}, {white_width_frame4, white_width_frame3},
    {light_width_frame2, light_width_frame1}, {light_width_frame4, light_width_frame3},
    {dark_width_frame2, dark_width_frame1}, {dark_width_frame4, dark_width_frame3},
    {black_width_frame2, black_width_frame1}, {black_width_frame4, black_width_frame3}};
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize
  initial begin
    #100us;
    err_count++;
    summarize();
  end
  initial begin
    repeat (4) @(posedge mclk);
    #5 rst_n = 1'b1;
    `CHK({got[0], got[7], arg_pending}, 17'h0)
    for (int i = 0; i < 8; i++) begin
      i_host.send(1'b0, {5'h11, 3'(i)});
      i_host.send(1'b0, rows[i]);
      `CHK(got[i], rows[i])
    end
    i_host.send(1'b0, 8'h89);
    i_host.send(1'b0, 8'h8F);
    `CHK({got[1], arg_pending}, 9'h11E)
    i_host.send(1'b1, 8'h8E);
    `CHK(arg_pending, 1'b0)
    i_host.send(1'b0, 8'h87);
    `CHK(arg_pending, 1'b0)
    i_host.send(1'b0, 8'h8C);
    i_host.send(1'b1, 8'h33);
    `CHK(arg_pending, 1'b1)
    i_host.send(1'b0, 8'h5A);
    `CHK({got[4], got[6]}, {8'h5A, rows[6]})
    i_host.send(1'b0, 8'h8A);
    @(posedge mclk) #5 soft_reset = 1'b1;
    @(posedge mclk) #5 soft_reset = 1'b0;
    `CHK({got[0], got[7], arg_pending}, 17'h0)
    i_host.send(1'b0, 8'h8E);
    i_host.send(1'b0, 8'h3C);
    `CHK(got[6], 8'h3C)
    i_host.send(1'b0, 8'h88);
    @(posedge mclk) #5 rst_n = 1'b0;
    @(posedge mclk) #5 rst_n = 1'b1;
    `CHK({got[6], arg_pending}, 9'h0)
    i_host.send(1'b0, 8'h8E);
    i_host.send(1'b0, 8'h41);
    `CHK({got[6], got[0]}, 16'h4100)
    summarize();
  end
endmodule : gray_palette_command_decode_tb
